// >>> regbuf_pkg.sv
// shared constants for the configurable registered buffer
package regbuf_pkg;

	// ********************************************************************
	// widths and pin configurations
	// ********************************************************************
	localparam int unsigned DATA_W = 25;
	localparam int unsigned PAIR_W = 14;

	typedef enum logic [1:0] {
		MODE_ONE_TO_ONE = 2'b00,
		MODE_LAYOUT_A   = 2'b01,
		MODE_LAYOUT_B   = 2'b11
	} mode_type;

	// active data bits per configuration, bit n of the vector is input n
	localparam logic [DATA_W:1] MASK_ONE_TO_ONE = 25'h1ffffb6;
	localparam logic [DATA_W:1] MASK_LAYOUT_A   = 25'h0003fb6;
	localparam logic [DATA_W:1] MASK_LAYOUT_B   = 25'h0001bbf;

	// ********************************************************************
	// reset values
	// ********************************************************************
	localparam logic [DATA_W:1] DATA_RST  = 25'h0000000;
	localparam logic [PAIR_W:1] PAIR_RST  = 14'h0000;
	localparam logic            CTRL_RST  = 1'b0;
	localparam logic [1:0]      STRAP_RST = 2'h0;

endpackage

// >>> hold_reg.sv
// register bank that loads only when enabled, cleared by asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module hold_reg #(
	parameter int unsigned WIDTH = 25
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (load) begin
			q <= d;
		end
	end

endmodule
`default_nettype wire

// >>> regbuf_top.sv
// configurable registered buffer: 25-bit one-to-one or 14-bit one-to-two
//
// Functional notes
// - capture active inputs on each clock crossing
// - async low reset clears every register
// - both selects high freezes ordinary data outputs
// - only ordinary data outputs obey select hold
// - select, termination, clock-enable outputs always update
// - both config low: 25-bit one-to-one mapping
// - layout A: 2,3,5,6,8-14 drive A and B
// - layout B: 1-6,8-10,12,13 drive A and B
// - layout A: every register has A and B copies
// - layout B: termination, clock-enable at bits 11,14; here they drive term_ctrl_out_a/b and clk_en_out_a/b
// - reset overrides selects, forces all outputs low
// - no clock crossing: outputs keep state
// - either select low: data outputs follow inputs
`timescale 1ns/1ns
`default_nettype none
module regbuf_top (
	input  wire logic                          clk_sys,
	input  wire logic                          rst_n,
	input  wire logic                          layout_select,
	input  wire logic                          width_select,
	input  wire logic                          impedance_sel_high,
	input  wire logic                          impedance_sel_low,
	input  wire logic                          primary_select_n,
	input  wire logic                          secondary_select_n,
	input  wire logic                          term_ctrl_in,
	input  wire logic                          clk_en_in,
	input  wire logic [regbuf_pkg::DATA_W:1]   data_in_bits,
	output var  logic [regbuf_pkg::DATA_W:1]   data_out_bits,
	output var  logic [regbuf_pkg::PAIR_W:1]   data_out_bits_b,
	output var  logic                          registered_select_out,
	output var  logic                          registered_select_out_a,
	output var  logic                          registered_select_out_b,
	output var  logic                          term_ctrl_out,
	output var  logic                          term_ctrl_out_a,
	output var  logic                          term_ctrl_out_b,
	output var  logic                          clk_en_out,
	output var  logic                          clk_en_out_a,
	output var  logic                          clk_en_out_b
);

	// ********************************************************************
	// configuration straps
	// ********************************************************************
	// straps are asynchronous pins, so two flops before use; they are
	// expected static, changing only while reset is low
	logic [1:0]                 strap_meta_r;
	logic [1:0]                 strap_r;
	regbuf_pkg::mode_type       mode;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_meta_r <= regbuf_pkg::STRAP_RST;
			strap_r      <= regbuf_pkg::STRAP_RST;
		end else begin
			strap_meta_r <= {layout_select, width_select};
			strap_r      <= strap_meta_r;
		end
	end

	// layout high with width low is undefined and falls back to 1:1, so a
	// mis-strapped board still gets a sane pinout
	function automatic regbuf_pkg::mode_type decode_mode(
		input logic [1:0] straps
	);
		regbuf_pkg::mode_type r;
		if (!straps[0]) begin
			r = regbuf_pkg::MODE_ONE_TO_ONE;
		end else if (straps[1]) begin
			r = regbuf_pkg::MODE_LAYOUT_B;
		end else begin
			r = regbuf_pkg::MODE_LAYOUT_A;
		end
		return r;
	endfunction

	// for two edges after reset the synced straps still read 00, so the
	// controller must hold its first command back until the third edge
	assign mode = decode_mode(strap_r);

	// ********************************************************************
	// decoding
	// ********************************************************************
	function automatic logic [regbuf_pkg::DATA_W:1] active_mask(
		input regbuf_pkg::mode_type m
	);
		logic [regbuf_pkg::DATA_W:1] r;
		r = regbuf_pkg::MASK_ONE_TO_ONE;
		unique case (m)
			regbuf_pkg::MODE_ONE_TO_ONE: r = regbuf_pkg::MASK_ONE_TO_ONE;
			regbuf_pkg::MODE_LAYOUT_A:   r = regbuf_pkg::MASK_LAYOUT_A;
			regbuf_pkg::MODE_LAYOUT_B:   r = regbuf_pkg::MASK_LAYOUT_B;
			default:                     r = regbuf_pkg::MASK_ONE_TO_ONE;
		endcase
		return r;
	endfunction

	// impedance selects are reserved and deliberately unread
	wire                              pair_mode;
	wire                              data_load;
	wire [regbuf_pkg::DATA_W:1]       data_masked;
	wire [regbuf_pkg::PAIR_W:1]       pair_next;
	wire [regbuf_pkg::DATA_W:1]       single_q;
	wire [regbuf_pkg::PAIR_W:1]       pair_q;

	assign pair_mode   = (mode != regbuf_pkg::MODE_ONE_TO_ONE);
	// hold only when both selects sampled high
	assign data_load   = !(primary_select_n && secondary_select_n);
	assign data_masked = data_in_bits & active_mask(mode);
	assign pair_next   = pair_mode ? data_masked[regbuf_pkg::PAIR_W:1]
		: regbuf_pkg::PAIR_RST;

	// ********************************************************************
	// gated data registers
	// ********************************************************************
	// the A copy of a pair shares the single-output register, the B copy
	// has its own flops so both copies come straight from registers
	hold_reg #(
		.WIDTH(regbuf_pkg::DATA_W)
	) u_single (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.load    (data_load),
		.d       (data_masked),
		.q       (single_q)
	);

	hold_reg #(
		.WIDTH(regbuf_pkg::PAIR_W)
	) u_pair_b (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.load    (data_load),
		.d       (pair_next),
		.q       (pair_q)
	);

	assign data_out_bits   = single_q;
	assign data_out_bits_b = pair_q;

	// ********************************************************************
	// ungated control registers
	// ********************************************************************
	// select, termination and clock enable ignore the hold; in 1:1 only the
	// plain outputs carry them, in 1:2 only the A and B copies
	logic sel_nxt;
	logic sel_pair_nxt;
	logic term_nxt;
	logic term_pair_nxt;
	logic cke_nxt;
	logic cke_pair_nxt;

	// in 1:1 only the plain control output carries the captured level
	function automatic logic plain_route(
		input logic pair,
		input logic v
	);
		logic r;
		r = pair ? regbuf_pkg::CTRL_RST : v;
		return r;
	endfunction

	// in 1:2 only the A and B copies carry it; the plain output idles low
	function automatic logic pair_route(
		input logic pair,
		input logic v
	);
		logic r;
		r = pair ? v : regbuf_pkg::CTRL_RST;
		return r;
	endfunction

	assign sel_nxt       = plain_route(pair_mode, primary_select_n);
	assign sel_pair_nxt  = pair_route(pair_mode, primary_select_n);
	assign term_nxt      = plain_route(pair_mode, term_ctrl_in);
	// in layout B these still drive the separate A and B copies; bits 11 and 14 of the pair stay low
	assign term_pair_nxt = pair_route(pair_mode, term_ctrl_in);
	assign cke_nxt       = plain_route(pair_mode, clk_en_in);
	assign cke_pair_nxt  = pair_route(pair_mode, clk_en_in);

	// select copies
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			registered_select_out   <= regbuf_pkg::CTRL_RST;
			registered_select_out_a <= regbuf_pkg::CTRL_RST;
			registered_select_out_b <= regbuf_pkg::CTRL_RST;
		end else begin
			registered_select_out   <= sel_nxt;
			registered_select_out_a <= sel_pair_nxt;
			registered_select_out_b <= sel_pair_nxt;
		end
	end

	// termination copies
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			term_ctrl_out           <= regbuf_pkg::CTRL_RST;
			term_ctrl_out_a         <= regbuf_pkg::CTRL_RST;
			term_ctrl_out_b         <= regbuf_pkg::CTRL_RST;
		end else begin
			term_ctrl_out           <= term_nxt;
			term_ctrl_out_a         <= term_pair_nxt;
			term_ctrl_out_b         <= term_pair_nxt;
		end
	end

	// clock-enable copies
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clk_en_out              <= regbuf_pkg::CTRL_RST;
			clk_en_out_a            <= regbuf_pkg::CTRL_RST;
			clk_en_out_b            <= regbuf_pkg::CTRL_RST;
		end else begin
			clk_en_out              <= cke_nxt;
			clk_en_out_a            <= cke_pair_nxt;
			clk_en_out_b            <= cke_pair_nxt;
		end
	end

endmodule
`default_nettype wire

// >>> regbuf_chk.sv
// concurrent checks on the ports of the registered buffer
`timescale 1ns/1ns
`default_nettype none
module regbuf_chk (
	input wire logic clk_sys, rst_n, layout_select, width_select, impedance_sel_high,
	input wire logic impedance_sel_low, primary_select_n, secondary_select_n, term_ctrl_in,
	input wire logic clk_en_in,
	input wire logic [regbuf_pkg::DATA_W:1] data_in_bits, data_out_bits,
	input wire logic [regbuf_pkg::PAIR_W:1] data_out_bits_b,
	input wire logic registered_select_out, registered_select_out_a, registered_select_out_b,
	input wire logic term_ctrl_out, term_ctrl_out_a, term_ctrl_out_b,
	input wire logic clk_en_out, clk_en_out_a, clk_en_out_b
);
	// ********************************************************************
	// strap settling: 1:2 checks wait until the synced straps are final
	// ********************************************************************
	logic [1:0] cnt_r;
	wire        held = primary_select_n && secondary_select_n;
	wire        wide = (cnt_r == 2'h3) && width_select;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) cnt_r <= 2'h0;
		else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_hold; held |=> $stable(data_out_bits) && $stable(data_out_bits_b); endproperty
	a_hold: assert property (p_hold) else $error("data moved while deselected");
	property p_cs11; !width_select |=> registered_select_out == $past(primary_select_n); endproperty
	a_cs11: assert property (p_cs11) else $error("select output wrong in 1:1");
	property p_ctl11; !width_select |=> term_ctrl_out == $past(term_ctrl_in)
		&& clk_en_out == $past(clk_en_in); endproperty
	a_ctl11: assert property (p_ctl11) else $error("control output wrong in 1:1");
	property p_cs12; wide |=> registered_select_out_a == $past(primary_select_n)
		&& registered_select_out_b == registered_select_out_a; endproperty
	a_cs12: assert property (p_cs12) else $error("select copies wrong in 1:2");
	property p_ctl12; wide |=> term_ctrl_out_a == $past(term_ctrl_in) && term_ctrl_out_b ==
		term_ctrl_out_a && clk_en_out_a == $past(clk_en_in) && clk_en_out_b == clk_en_out_a;
	endproperty
	a_ctl12: assert property (p_ctl12) else $error("control copies wrong in 1:2");
	property p_d11; !width_select && !held |=>
		data_out_bits == ($past(data_in_bits) & regbuf_pkg::MASK_ONE_TO_ONE); endproperty
	a_d11: assert property (p_d11) else $error("1:1 data wrong");
	property p_d12; wide && !held |=> data_out_bits == ($past(data_in_bits) & (layout_select
		? regbuf_pkg::MASK_LAYOUT_B : regbuf_pkg::MASK_LAYOUT_A)); endproperty
	a_d12: assert property (p_d12) else $error("1:2 data wrong");
	property p_copy; wide |-> data_out_bits_b == data_out_bits[14:1]; endproperty
	a_copy: assert property (p_copy) else $error("B copy differs");
	property p_rst; disable iff (1'b0) !rst_n |-> data_out_bits == 25'h0000000 && !clk_en_out
		&& !registered_select_out && !term_ctrl_out_a; endproperty
	a_rst: assert property (p_rst) else $error("outputs not low in reset");
endmodule
bind regbuf_top regbuf_chk i_chk (.*);
`default_nettype wire

// >>> memctl_model.sv
// controller-side model for the reserved impedance select pins
`timescale 1ns/1ns
`default_nettype none
module memctl_model (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	output var  logic impedance_sel_high,
	output var  logic impedance_sel_low
);
	// reserved pins wander every cycle so nothing can lean on them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) {impedance_sel_high, impedance_sel_low} <= 2'h1;
		else {impedance_sel_high, impedance_sel_low} <= {impedance_sel_low, ~impedance_sel_high};
	end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the registered buffer in all three layouts
`timescale 1ns/1ns
`default_nettype none
module tb;
	// reset starts high so its first fall clears the flops before any check
	logic clk_sys = 1'b0, rst_n = 1'b1, ls = 1'b0, ws = 1'b0;
	logic pri = 1'b1, sec = 1'b1, term = 1'b0, cke = 1'b0, zh, zl;
	logic [25:1] din = 25'h0000000, eq, m, q;
	logic [14:1] qb;
	logic cs, csa, csb, od, oda, odb, ce, cea, ceb;
	int mismatches = 0, compares = 0;
	always #20 clk_sys = ~clk_sys;
	memctl_model i_mc (.clk_sys(clk_sys), .rst_n(rst_n), .impedance_sel_high(zh),
		.impedance_sel_low(zl));
	regbuf_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .layout_select(ls), .width_select(ws),
		.impedance_sel_high(zh), .impedance_sel_low(zl), .primary_select_n(pri),
		.secondary_select_n(sec), .term_ctrl_in(term), .clk_en_in(cke), .data_in_bits(din),
		.data_out_bits(q), .data_out_bits_b(qb), .registered_select_out(cs),
		.registered_select_out_a(csa), .registered_select_out_b(csb), .term_ctrl_out(od),
		.term_ctrl_out_a(oda), .term_ctrl_out_b(odb), .clk_en_out(ce), .clk_en_out_a(cea),
		.clk_en_out_b(ceb));
	task chk(input logic [47:0] s, input logic [47:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task give_verdict;
		if (mismatches == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one capture edge per call; held data keeps the last loaded value
	task put(input logic p, input logic s, input logic t, input logic k, input logic [25:1] d);
		@(posedge clk_sys);
		pri <= p; sec <= s; term <= t; cke <= k; din <= d;
		@(posedge clk_sys);
		#1;
		if (!(p && s)) eq = d & m;
		chk({q, qb}, {eq, ws ? eq[14:1] : 14'h0000});
		chk({cs, csa, csb, od, oda, odb, ce, cea, ceb},
			ws ? {1'b0, p, p, 1'b0, t, t, 1'b0, k, k} : {p, 2'h0, t, 2'h0, k, 2'h0});
	endtask
	initial begin
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			rst_n <= 1'b0;
			ls <= (i == 2);
			ws <= (i > 0);
			eq = 25'h0000000;
			repeat (8) @(posedge clk_sys);
			rst_n <= 1'b1;
			repeat (3) @(posedge clk_sys);
			m = (i == 0) ? regbuf_pkg::MASK_ONE_TO_ONE
				: (i == 1) ? regbuf_pkg::MASK_LAYOUT_A : regbuf_pkg::MASK_LAYOUT_B;
			put(1'b0, 1'b1, 1'b1, 1'b0, 25'h1555555);
			put(1'b1, 1'b1, 1'b0, 1'b1, 25'h0aaaaaa);
			put(1'b1, 1'b0, 1'b1, 1'b1, 25'h1ffffff);
			put(1'b0, 1'b0, 1'b0, 1'b0, 25'h1234567);
			@(posedge clk_sys);
			rst_n <= 1'b0;
			#1;
			chk({q, qb, cs, csa, csb, od, oda, odb, ce, cea, ceb}, 48'h000000000000);
		end
		give_verdict;
	end
endmodule
`default_nettype wire
